// File: bhc_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) at or below band bottom the heater command is 100 percent
// (RULE_02) at or above band top the command is zero, falling in between
// (RULE_03) output linear across the band, band centred on set-point; at band index 6 the code keeps only the low 7 bits of diff times 100
// (RULE_04) band width chosen from discrete steps in current units
// (RULE_05) set plus exit opens secondary menu at heater power; set advances
// (RULE_06) band: up/down adjust, set accepts to cut-out, exit discards
// (RULE_07) heater power removed while temperature exceeds cut-out level
// (RULE_08) automatic mode clears trip below level minus a few degrees
// (RULE_09) manual mode keeps heater off until operator clears trip
// (RULE_10) manual trip flashes display; two set presses clear when below level
// (RULE_11) cut-out level: adjust, set to config prompt, exit to display
// (RULE_12) config prompt then set offers five groups chosen by up/down
// (RULE_13) probe parameter: set opens, up/down change, set stores, exit skips
// (RULE_14) probe ice resistance 100.000 ohm, coefficient 0.00385 per degree
// (RULE_15) recovery mode defaults to manual; up then set selects automatic
// (RULE_16) automatic stirrer runs only above stirrer threshold
// (RULE_17) always-on stirrer runs whenever powered
// (RULE_18) stirrer threshold opened from activation item, adjusted, stored
// (RULE_19) low heat-up caps power below 30 percent until 200 C
// (RULE_20) heat-up option toggled by up/down, stored by set
// (RULE_21) high heat-up applies no extra limit
// (RULE_22) heater is time-proportioned: on-slots over cycle slots
module bhc_ctrl
    import bhc_pkg::*;
(
    input  wire logic                 i_ref_clk,       // 125 MHz clock
    input  wire logic                 i_srst,          // sync reset, high
    input  wire logic                 i_key_set,       // panel key, async
    input  wire logic                 i_key_exit,      // panel key, async
    input  wire logic                 i_key_up,        // panel key, async
    input  wire logic                 i_key_down,      // panel key, async
    input  wire logic                 i_units_f,       // 1: Fahrenheit
    input  wire logic signed [TW-1:0] i_bath_temp,     // probe reading
    input  wire logic signed [TW-1:0] i_setpoint,      // active set-point
    output logic                      o_heater_on,     // heater switch
    output logic                      o_stirrer_on,    // stirrer motor
    output logic [6:0]                o_heater_pct,    // commanded percent
    output logic                      o_cutout_trip,   // cut-out latched
    output logic                      o_cutout_flash,  // blink indication
    output logic [4:0]                o_menu_state,    // panel function
    output logic signed [TW-1:0]      o_disp_value,    // value shown
    output logic [2:0]                o_group_sel,     // config group
    output logic [2:0]                o_band_idx,      // band step index
    output logic signed [TW-1:0]      o_ice_res,       // milliohm
    output logic signed [TW-1:0]      o_temp_coef      // 1e-5 per degree
);
    logic [KEYS-1:0]  keys_in;
    logic [2:0]       sync_q [KEYS];
    logic [KEYS-1:0]  key_lvl;
    logic [KEYS-1:0]  key_lvl_d;
    logic [KEYS-1:0]  press;
    logic             combo;
    bhc_state_t       state;
    bhc_state_t       next_state;
    logic signed [TW-1:0] edit;
    logic signed [TW-1:0] cutout_lvl;
    logic signed [TW-1:0] stir_lvl;
    logic             cutout_auto;
    logic             stir_always;
    logic             heatup_low;
    logic signed [TW:0] half_w;
    logic signed [TW:0] band_lo;
    logic signed [TW:0] band_hi;
    logic signed [TW:0] t_ext;
    logic [9:0]       diff;
    logic [16:0]      scaled;
    logic [6:0]       next_pct;
    logic [6:0]       pct_hold;
    logic [SLOT_W-1:0] slot_cnt;
    logic [6:0]       slot_idx;
    logic             slot_end;
    logic signed [TW-1:0] heatup_lvl;

    assign keys_in = {i_key_down, i_key_up, i_key_exit, i_key_set};

    // three stages per key; a level change is taken when stages two and
    // three agree, which also rejects single-cycle glitches
    for (genvar k = 0; k < KEYS; k++) begin : g_key
        always_ff @(posedge i_ref_clk) begin
            if (i_srst) begin
                sync_q[k]    <= 3'h0;
                key_lvl[k]   <= 1'b0;
                key_lvl_d[k] <= 1'b0;
            end else begin
                sync_q[k] <= {sync_q[k][1:0], keys_in[k]};
                if (sync_q[k][1] == sync_q[k][2]) begin
                    key_lvl[k] <= sync_q[k][2];
                end
                key_lvl_d[k] <= key_lvl[k];
            end
        end
        assign press[k] = key_lvl[k] & ~key_lvl_d[k];
    end

    // (RULE_05) set and exit held together
    assign combo = key_lvl[K_SET] & key_lvl[K_EXIT] &
                   (press[K_SET] | press[K_EXIT]);

    always_comb begin
        next_state = state;
        if (combo) begin
            next_state = S_POWER;
        end else if (press[K_EXIT]) begin
            unique case (state)
                // (RULE_13) exit skips the parameter being edited
                S_R0_ED:    next_state = S_PROBE_TEMP_COEFFICIENT;
                S_PROBE_TEMP_COEFFICIENT_ED: next_state = S_GROUP;
                S_CO_ED:    next_state = S_STIR_ACT;
                S_STA_ED:   next_state = S_STIR_SET;
                S_STS_ED:   next_state = S_HEATUP;
                S_HU_ED:    next_state = S_GROUP;
                default:    next_state = S_TEMP;
            endcase
        end else if (press[K_SET]) begin
            unique case (state)
                S_TEMP:     next_state = cutout_auto ? S_TEMP : S_RST_ASK;
                S_RST_ASK:  next_state = S_TEMP;
                S_POWER:    next_state = S_BAND;
                S_BAND:     next_state = S_CUTOUT;
                S_CUTOUT:   next_state = S_CONFIG;
                S_CONFIG:   next_state = S_GROUP;
                // (RULE_12) only probe and operating groups are built here
                S_GROUP:    next_state = (edit[2:0] == GROUP_PROBE) ? S_R0 :
                                         (edit[2:0] == GROUP_OPER) ?
                                         S_CO_MODE : S_GROUP;
                S_R0:       next_state = S_R0_ED;
                S_R0_ED:    next_state = S_PROBE_TEMP_COEFFICIENT;
                S_PROBE_TEMP_COEFFICIENT:    next_state = S_PROBE_TEMP_COEFFICIENT_ED;
                S_PROBE_TEMP_COEFFICIENT_ED: next_state = S_GROUP;
                S_CO_MODE:  next_state = S_CO_ED;
                S_CO_ED:    next_state = S_STIR_ACT;
                S_STIR_ACT: next_state = S_STA_ED;
                // (RULE_18) threshold follows the activation item
                S_STA_ED:   next_state = S_STIR_SET;
                S_STIR_SET: next_state = S_STS_ED;
                S_STS_ED:   next_state = S_HEATUP;
                S_HEATUP:   next_state = S_HU_ED;
                S_HU_ED:    next_state = S_GROUP;
                default:    next_state = S_TEMP;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state <= S_TEMP;
        end else begin
            state <= next_state;
        end
    end

    // edit buffer: loaded on entry, stepped by up/down, written back on set
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            edit <= '0;
        end else if (next_state != state) begin
            unique case (next_state)
                S_BAND:   edit <= TW'(o_band_idx);
                S_CUTOUT: edit <= cutout_lvl;
                S_GROUP:  edit <= '0;
                S_R0_ED:  edit <= o_ice_res;
                S_PROBE_TEMP_COEFFICIENT_ED: edit <= o_temp_coef;
                S_CO_ED:  edit <= TW'(cutout_auto);
                S_STA_ED: edit <= TW'(stir_always);
                S_STS_ED: edit <= stir_lvl;
                S_HU_ED:  edit <= TW'(heatup_low);
                default:  edit <= edit;
            endcase
        end else if (press[K_UP] | press[K_DOWN]) begin
            unique case (state)
                // (RULE_04) band index saturates at the table ends
                S_BAND: begin
                    if (press[K_UP] && edit[2:0] != 3'h7) begin
                        edit <= edit + 1'b1;
                    end else if (press[K_DOWN] && edit[2:0] != 3'h0) begin
                        edit <= edit - 1'b1;
                    end
                end
                S_GROUP: begin
                    if (press[K_UP] && edit[2:0] != GROUP_LAST) begin
                        edit <= edit + 1'b1;
                    end else if (press[K_DOWN] && edit[2:0] != 3'h0) begin
                        edit <= edit - 1'b1;
                    end
                end
                // (RULE_15) (RULE_20) two-way options toggle
                S_CO_ED, S_STA_ED, S_HU_ED: edit <= TW'(~edit[0]);
                S_CUTOUT, S_R0_ED, S_PROBE_TEMP_COEFFICIENT_ED, S_STS_ED: begin
                    edit <= press[K_UP] ? edit + 1'b1 : edit - 1'b1;
                end
                default: edit <= edit;
            endcase
        end
    end

    // stored settings change only on set; exit leaves them untouched
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_band_idx  <= BAND_IDX_RST;
            cutout_lvl  <= CUTOUT_RST;
            // (RULE_14) probe defaults
            o_ice_res   <= ICE_RES_RST;
            o_temp_coef <= TEMP_COEF_RST;
            // (RULE_15) manual recovery after reset
            cutout_auto <= 1'b0;
            stir_always <= 1'b0;
            stir_lvl    <= STIR_LVL_RST;
            heatup_low  <= 1'b1;
        end else if (press[K_SET] && !combo) begin
            unique case (state)
                // (RULE_06) accept band
                S_BAND:     o_band_idx  <= edit[2:0];
                // (RULE_11) accept cut-out level
                S_CUTOUT:   cutout_lvl  <= edit;
                S_R0_ED:    o_ice_res   <= edit;
                S_PROBE_TEMP_COEFFICIENT_ED: o_temp_coef <= edit;
                S_CO_ED:    cutout_auto <= edit[0];
                S_STA_ED:   stir_always <= edit[0];
                S_STS_ED:   stir_lvl    <= edit;
                S_HU_ED:    heatup_low  <= edit[0];
                default:    heatup_low  <= heatup_low;
            endcase
        end
    end

    // (RULE_03) band of 2^(idx+2) hundredths for idx 0 to 6 (2 for idx 7), centred on the set-point
    assign half_w  = (TW+1)'(1) <<< (o_band_idx + 3'(BAND_SHIFT0 - 1));
    assign t_ext   = (TW+1)'(i_bath_temp);
    assign band_lo = (TW+1)'(i_setpoint) - half_w;
    assign band_hi = (TW+1)'(i_setpoint) + half_w;
    assign diff    = 10'(band_hi - t_ext);
    assign scaled  = (17'(diff) * 17'd100) >> (o_band_idx + 3'(BAND_SHIFT0));
    assign heatup_lvl = i_units_f ? HEATUP_LVL_F : HEATUP_LVL_C;

    always_comb begin
        // (RULE_01) full output at the bottom edge
        if (t_ext <= band_lo) begin
            next_pct = PCT_FULL;
        // (RULE_02) nothing at the top edge
        end else if (t_ext >= band_hi) begin
            next_pct = 7'h00;
        end else begin
            next_pct = scaled[6:0];
        end
        // (RULE_19) (RULE_21) cap only in low heat-up below 200 C
        if (heatup_low && i_bath_temp < heatup_lvl && next_pct > PCT_HEATUP) begin
            next_pct = PCT_HEATUP;
        end
        // (RULE_07) nothing while tripped
        if (o_cutout_trip) begin
            next_pct = 7'h00;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_heater_pct <= 7'h00;
        end else begin
            o_heater_pct <= next_pct;
        end
    end

    // (RULE_07) (RULE_08) (RULE_09) (RULE_10) trip and recovery
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_cutout_trip <= 1'b0;
        end else if (i_bath_temp > cutout_lvl) begin
            o_cutout_trip <= 1'b1;
        end else if (cutout_auto && i_bath_temp < cutout_lvl - CUTOUT_HYST) begin
            o_cutout_trip <= 1'b0;
        end else if (!cutout_auto && state == S_RST_ASK && press[K_SET] &&
                     !combo) begin
            o_cutout_trip <= 1'b0;
        end
    end

    // (RULE_22) 100 slots per cycle; percent latched per cycle so a
    // mid-cycle change cannot give a double pulse
    assign slot_end = (slot_cnt == SLOT_W'(SLOT_CYCLES - 1));
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            slot_cnt <= '0;
            slot_idx <= 7'h00;
            pct_hold <= 7'h00;
            o_cutout_flash <= 1'b0;
        end else begin
            slot_cnt <= slot_end ? '0 : slot_cnt + 1'b1;
            if (slot_end) begin
                slot_idx <= (slot_idx == PCT_FULL - 7'h01) ? 7'h00 :
                            slot_idx + 1'b1;
                if (slot_idx == PCT_FULL - 7'h01) begin
                    pct_hold <= o_heater_pct;
                    o_cutout_flash <= o_cutout_trip & ~cutout_auto &
                                      ~o_cutout_flash;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_heater_on  <= 1'b0;
            o_stirrer_on <= 1'b0;
            o_menu_state <= 5'h00;
            o_disp_value <= '0;
            o_group_sel  <= 3'h0;
        end else begin
            // (RULE_07) trip overrides the slot pattern at once
            o_heater_on  <= (slot_idx < pct_hold) && !o_cutout_trip;
            // (RULE_16) (RULE_17) stirrer control
            o_stirrer_on <= stir_always || (i_bath_temp > stir_lvl);
            o_menu_state <= state;
            o_disp_value <= (state == S_TEMP) ? i_bath_temp :
                            (state == S_POWER) ? TW'(o_heater_pct) : edit;
            o_group_sel  <= (state == S_GROUP) ? edit[2:0] : o_group_sel;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    sequence combo_press;
        combo;
    endsequence

    chk_full_low: assert property (t_ext <= band_lo && !o_cutout_trip && // RULE_01
        !heatup_low |=> o_heater_pct == PCT_FULL)
        else $error("full output missing below band");
    chk_zero_high: assert property (t_ext >= band_hi |=> // RULE_02
        o_heater_pct == 7'h00)
        else $error("output not zero above band");
    chk_trip_set: assert property (i_bath_temp > cutout_lvl |=> // RULE_07
        o_cutout_trip ##1 !o_heater_on)
        else $error("cut-out did not remove heat");
    chk_manual_hold: assert property (o_cutout_trip && !cutout_auto && // RULE_09
        state != S_RST_ASK |=> o_cutout_trip)
        else $error("manual trip cleared without operator");
    chk_combo_entry: assert property (combo_press |=> // RULE_05
        state == S_POWER)
        else $error("secondary menu not entered");
    chk_stir_always: assert property (stir_always |=> o_stirrer_on) // RULE_17
        else $error("stirrer off in always-on mode");
    chk_heatup_cap: assert property (heatup_low && // RULE_19
        i_bath_temp < heatup_lvl |=> o_heater_pct <= PCT_HEATUP)
        else $error("heat-up cap exceeded");
    chk_band_drop: assert property (state == S_BAND && press[K_EXIT] && // RULE_06
        !combo |=> $stable(o_band_idx) && state == S_TEMP)
        else $error("band change kept on exit");
endmodule

// File: bhc_panel_model.sv
`timescale 1ns/1ps
module bhc_panel_model
    import bhc_pkg::*;
(
    input  wire logic                 i_ref_clk,   // system clock
    input  wire logic [KEYS-1:0]      i_key_req,   // keys the operator holds
    input  wire logic signed [TW-1:0] i_temp_req,  // bath temperature wanted
    output logic                      o_key_set,   // set key contact
    output logic                      o_key_exit,  // exit key contact
    output logic                      o_key_up,    // up key contact
    output logic                      o_key_down,  // down key contact
    output logic signed [TW-1:0]      o_bath_temp  // probe reading
);
    // contacts idle open and the probe reads cold until the first edge
    initial begin
        o_key_set   = 1'b0;
        o_key_exit  = 1'b0;
        o_key_up    = 1'b0;
        o_key_down  = 1'b0;
        o_bath_temp = 20'sh009c4;
    end

    // everything moves just after an edge, one cycle behind the operator
    always @(posedge i_ref_clk) begin
        o_key_set   <= i_key_req[K_SET];
        o_key_exit  <= i_key_req[K_EXIT];
        o_key_up    <= i_key_req[K_UP];
        o_key_down  <= i_key_req[K_DOWN];
        o_bath_temp <= i_temp_req;
    end
endmodule

// File: bhc_pkg.sv
package bhc_pkg;
    // temperatures are signed hundredths of a degree in the selected units
    localparam int TW             = 20;
    localparam int BAND_IW        = 3;
    localparam int BAND_SHIFT0    = 2;
    localparam logic [2:0] BAND_IDX_RST = 3'h3;
    localparam logic signed [19:0] CUTOUT_RST   = 20'sh05208;
    localparam logic signed [19:0] CUTOUT_HYST  = 20'sh0012c;
    localparam logic signed [19:0] STIR_LVL_RST = 20'sh04e20;
    localparam logic signed [19:0] HEATUP_LVL_C = 20'sh04e20;
    localparam logic signed [19:0] HEATUP_LVL_F = 20'sh09920;
    localparam logic signed [19:0] ICE_RES_RST  = 20'sh186a0;
    localparam logic signed [19:0] TEMP_COEF_RST = 20'sh00181;
    localparam logic [6:0] PCT_FULL   = 7'h64;
    localparam logic [6:0] PCT_HEATUP = 7'h1d;
    localparam logic [2:0] GROUP_LAST = 3'h4;
    localparam logic [2:0] GROUP_PROBE = 3'h0;
    localparam logic [2:0] GROUP_OPER  = 3'h1;
    localparam int REF_CLK_MHZ  = 125;
    localparam int SLOT_TIME_US = 20;
    localparam int SLOT_CYCLES  = SLOT_TIME_US * REF_CLK_MHZ;
    localparam int SLOT_W       = 12;
    localparam int KEYS   = 4;
    localparam int K_SET  = 0;
    localparam int K_EXIT = 1;
    localparam int K_UP   = 2;
    localparam int K_DOWN = 3;

    typedef enum logic [4:0] {
        S_TEMP     = 5'h00, S_RST_ASK  = 5'h01, S_POWER   = 5'h02,
        S_BAND     = 5'h03, S_CUTOUT   = 5'h04, S_CONFIG  = 5'h05,
        S_GROUP    = 5'h06, S_R0       = 5'h07, S_R0_ED   = 5'h08,
        S_PROBE_TEMP_COEFFICIENT    = 5'h09, S_PROBE_TEMP_COEFFICIENT_ED = 5'h0a, S_CO_MODE = 5'h0b,
        S_CO_ED    = 5'h0c, S_STIR_ACT = 5'h0d, S_STA_ED  = 5'h0e,
        S_STIR_SET = 5'h0f, S_STS_ED   = 5'h10, S_HEATUP  = 5'h11,
        S_HU_ED    = 5'h12
    } bhc_state_t;
endpackage

// File: tb.sv
`timescale 1ns/1ps
module tb;
    import bhc_pkg::*;
    typedef struct packed {
        logic [3:0]           sel;
        logic signed [TW-1:0] val;
    } bhc_note_t;

    logic                 i_ref_clk, i_srst, units_f, chk_req;
    logic [KEYS-1:0]      key_req;
    logic signed [TW-1:0] temp_req, setpoint, t, e;
    logic                 k_set, k_exit, k_up, k_down;
    logic signed [TW-1:0] bath, disp, ice, coef;
    logic                 heat_on, stir_on, trip, flash;
    logic [6:0]           pct;
    logic [4:0]           menu;
    logic [2:0]           grp, band;
    bhc_note_t            notes[$];
    bhc_note_t            nt;
    int                   mismatches, n_compared, cycles, d;
    integer               seed = 32'hd901190c;

    bhc_panel_model u_panel (.i_ref_clk(i_ref_clk), .i_key_req(key_req),
        .i_temp_req(temp_req), .o_key_set(k_set), .o_key_exit(k_exit),
        .o_key_up(k_up), .o_key_down(k_down), .o_bath_temp(bath));

    bhc_ctrl dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_key_set(k_set),
        .i_key_exit(k_exit), .i_key_up(k_up), .i_key_down(k_down),
        .i_units_f(units_f), .i_bath_temp(bath), .i_setpoint(setpoint),
        .o_heater_on(heat_on), .o_stirrer_on(stir_on), .o_heater_pct(pct),
        .o_cutout_trip(trip), .o_cutout_flash(flash), .o_menu_state(menu),
        .o_disp_value(disp), .o_group_sel(grp), .o_band_idx(band),
        .o_ice_res(ice), .o_temp_coef(coef));

    initial begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    // 0 pct, 1 trip, 2 menu, 3 band, 4 ice, 5 coef, 6 stirrer, 7 group
    function automatic logic signed [TW-1:0] got(input logic [3:0] s);
        case (s)
            4'h0: got = {13'h0, pct};
            4'h1: got = {19'h0, trip};
            4'h2: got = {15'h0, menu};
            4'h3: got = {17'h0, band};
            4'h4: got = ice;
            4'h5: got = coef;
            4'h6: got = {19'h0, stir_on};
            4'h7: got = {17'h0, grp};
            4'h9: got = {19'h0, heat_on};
            4'ha: got = {19'h0, flash};
            default: got = disp;
        endcase
    endfunction

    // outputs are looked at one edge after the note is posted
    always @(posedge i_ref_clk) begin
        if (chk_req) begin
            nt = notes.pop_front();
            n_compared++;
            if (got(nt.sel) !== nt.val) begin
                mismatches++;
                $display("BAD t=%0t sel %0d exp %h got %h", $time, nt.sel,
                         nt.val, got(nt.sel));
            end
        end
    end

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang costs a mismatch instead of a stuck run
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    task automatic want(input logic [3:0] s, input logic signed [TW-1:0] v);
        notes.push_back('{sel: s, val: v});
        chk_req <= 1'b1;
        step(1);
        chk_req <= 1'b0;
        step(1);
    endtask

    // keys are held past the synchroniser and released before the next one
    task automatic press(input logic [KEYS-1:0] k);
        key_req <= k;
        step(6);
        key_req <= 4'h0;
        step(6);
    endtask

    task automatic temp(input logic signed [TW-1:0] v);
        temp_req <= v;
        step(5);
    endtask

    initial begin
        i_srst = 1'b1;
        key_req = 4'h0;
        temp_req = 20'sh009c4;
        setpoint = 20'sh05014;
        units_f = 1'b0;
        chk_req = 1'b0;
        step(16);
        i_srst <= 1'b0;
        step(2);
        want(4'h3, 20'sh00003);
        want(4'h4, 20'sh186a0);
        want(4'h5, 20'sh00181);
        want(4'h2, S_TEMP);
        temp(20'sh05004);
        want(4'h0, 20'sh00064);
        temp(20'sh05024);
        want(4'h0, 20'sh00000);
        temp(20'sh05032);
        want(4'h0, 20'sh00000);
        for (int i = 0; i < 6; i++) begin
            d = {$random(seed)} % 33;
            t = 20'sh05004 + d[TW-1:0];
            e = TW'(((32 - d) * 100) >> 5);
            temp(t);
            want(4'h0, e);
        end
        temp(20'sh04e1f);
        want(4'h0, 20'sh0001d);
        units_f <= 1'b1;
        temp(20'sh05004);
        want(4'h0, 20'sh0001d);
        units_f <= 1'b0;
        temp(20'sh04e21);
        want(4'h6, 20'sh00001);
        temp(20'sh04e20);
        want(4'h6, 20'sh00000);
        // manual trip stays latched and refuses to clear while still hot
        temp(20'sh05209);
        want(4'h1, 20'sh00001);
        want(4'h0, 20'sh00000);
        want(4'h9, 20'sh00000);
        press(4'h1);
        want(4'h2, S_RST_ASK);
        press(4'h1);
        want(4'h1, 20'sh00001);
        press(4'h2);
        temp(20'sh04e20);
        want(4'h1, 20'sh00001);
        want(4'h0, 20'sh00000);
        press(4'h1);
        want(4'h2, S_RST_ASK);
        press(4'h1);
        want(4'h1, 20'sh00000);
        press(4'h2);
        want(4'h2, S_TEMP);
        // secondary menu walk: band up, cut-out down, probe and operating
        press(4'h3);
        want(4'h2, S_POWER);
        want(4'h8, 20'sh00064);
        press(4'h1);
        want(4'h2, S_BAND);
        press(4'h4);
        press(4'h1);
        want(4'h3, 20'sh00004);
        want(4'h2, S_CUTOUT);
        press(4'h8);
        press(4'h1);
        want(4'h2, S_CONFIG);
        press(4'h1);
        want(4'h2, S_GROUP);
        press(4'h4);
        want(4'h7, 20'sh00001);
        press(4'h8);
        want(4'h7, 20'sh00000);
        press(4'h1);
        want(4'h2, S_R0);
        press(4'h1);
        press(4'h4);
        press(4'h1);
        want(4'h4, 20'sh186a1);
        want(4'h2, S_PROBE_TEMP_COEFFICIENT);
        press(4'h1);
        press(4'h4);
        press(4'h2);
        want(4'h5, 20'sh00181);
        want(4'h2, S_GROUP);
        press(4'h4);
        press(4'h1);
        want(4'h2, S_CO_MODE);
        press(4'h1);
        press(4'h4);
        press(4'h1);
        want(4'h2, S_STIR_ACT);
        press(4'h1);
        press(4'h4);
        press(4'h1);
        want(4'h2, S_STIR_SET);
        press(4'h1);
        press(4'h1);
        want(4'h2, S_HEATUP);
        press(4'h1);
        press(4'h8);
        press(4'h1);
        want(4'h2, S_GROUP);
        press(4'h2);
        want(4'h2, S_TEMP);
        temp(20'sh009c4);
        want(4'h6, 20'sh00001);
        temp(20'sh04e1f);
        want(4'h0, 20'sh00064);
        temp(20'sh05024);
        want(4'h0, 20'sh00019);
        // cut-out now one below default and in automatic recovery
        temp(20'sh05208);
        want(4'h1, 20'sh00001);
        // automatic recovery shows no blinking cut-out indication
        want(4'ha, 20'sh00000);
        want(4'h9, 20'sh00000);
        temp(20'sh050dc);
        want(4'h1, 20'sh00001);
        temp(20'sh050da);
        want(4'h1, 20'sh00000);
        // still above the band here, so heating resumes only once cooler
        want(4'h0, 20'sh00000);
        temp(20'sh04e20);
        want(4'h0, 20'sh00064);
        press(4'h3);
        press(4'h1);
        press(4'h4);
        press(4'h2);
        want(4'h3, 20'sh00004);
        want(4'h2, S_TEMP);
        conclude();
    end
endmodule
